// >>> rtl/txh_top.sv
// Transmitter head configuration: serial port, channel choice, sync role and barrier numbering.
`timescale 1ns/100ps
module txh_top
   import txh_pkg::*;
#(
   parameter int unsigned CLKS_PER_BIT = CLKS_PER_BIT_DFLT,
   parameter int unsigned SHOW_CYCLES = SHOW_CYCLES_DFLT,
   parameter int unsigned SYNC_UNIT = SYNC_UNIT_DFLT
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic rs485_rx_in,
   output logic rs485_tx_out,
   output logic rs485_de_out,
   input wire logic [3:0] channel_selector_in,
   input wire logic [3:0] units_digit_switch_in,
   input wire logic [3:0] tens_digit_switch_in,
   input wire logic lock_pushbutton_in,
   input wire logic tamper_switch_in,
   input wire logic sync_role_jumper_in,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe_out,
   input wire logic channel_alarm_in,
   input wire logic intrusion_in,
   input wire logic tamper_cond_in,
   input wire logic fault_cond_in,
   output logic [3:0] modulation_channel_out,
   output logic [6:0] barrier_number_out,
   output logic alarm_event_out,
   output logic tamper_event_out,
   output logic fault_event_out,
   output logic fault_tens_indicator_out,
   output logic tamper_units_indicator_out
);
   localparam int unsigned SHOW_W = $clog2(SHOW_CYCLES + 1);
   localparam logic [SHOW_W-1:0] SHOW_LAST = SHOW_W'(SHOW_CYCLES - 1);
   localparam logic [SYNC_CNT_W-1:0] SYNC_UNIT_LAST = SYNC_CNT_W'(SYNC_UNIT - 1);

   if (CLKS_PER_BIT < 4 || SHOW_CYCLES < 1 || SYNC_UNIT < 1 || SYNC_UNIT * 16 >= (1 << SYNC_CNT_W)) begin : g_chk
      $error("txh_top: parameter out of range");
   end

   function automatic logic [6:0] digits_to_bin(input txh_digits_t d);
      digits_to_bin = 7'(d.tens) * DIGIT_WEIGHT_TENS + 7'(d.units);
   endfunction : digits_to_bin

   // Bus side.
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic access;
   logic done;
   logic wr_done;
   logic rd_done;
   logic mapped;
   logic [31:0] rd_mux;

   // Serial side.
   logic uart_busy;
   logic uart_rx_valid;
   logic [7:0] uart_rx_data;
   logic uart_rx_ferr;
   logic tx_start;
   logic rx_valid_r;
   logic rx_ferr_r;
   logic [7:0] rx_data_r;

   // Numbering.
   txh_num_state_t num_st_r;
   txh_digits_t sw;
   txh_digits_t stored_r;
   logic have_r;
   logic locked_r;
   logic [SHOW_W-1:0] show_cnt_r;
   logic btn_q_r;
   logic tmp_q_r;
   logic btn_rel;
   logic tmp_close;
   logic sw_zero;
   logic sw_valid;
   logic num_wr_ok;
   txh_digits_t wr_digits;

   // Channel and sync.
   logic slave;
   logic [3:0] active_ch;
   logic [3:0] slave_ch_r;
   logic sync_q_r;
   logic [SYNC_CNT_W-1:0] sync_pre_r;
   logic [3:0] sync_units_r;
   logic [SYNC_CNT_W-1:0] sync_cnt_r;
   logic [SYNC_CNT_W-1:0] sync_half;

   assign access = psel_in & penable_in & ~pready_r;
   assign done = psel_in & penable_in & pready_r;
   assign wr_done = done & pwrite_in & ~pslverr_r;
   assign rd_done = done & ~pwrite_in & ~pslverr_r;
   assign mapped = (paddr_in == ADDR_TXDATA) || (paddr_in == ADDR_RXDATA) ||
                   (paddr_in == ADDR_STATUS) || (paddr_in == ADDR_NUMBER);

   always_comb begin
      rd_mux = '0;
      unique case (paddr_in)
         ADDR_RXDATA: begin
            rd_mux[7:0] = rx_data_r;
            rd_mux[RX_VALID_BIT] = rx_valid_r;
            rd_mux[RX_FERR_BIT] = rx_ferr_r;
         end
         ADDR_STATUS: begin
            rd_mux[ST_CHAN_LSB +: 4] = active_ch;
            rd_mux[ST_SLAVE_BIT] = slave;
            rd_mux[ST_STATE_LSB +: 3] = num_st_r;
            rd_mux[ST_LOCKED_BIT] = locked_r;
            rd_mux[ST_REMOTE_BIT] = have_r;
            rd_mux[ST_TXBUSY_BIT] = uart_busy;
            rd_mux[ST_NUMBER_LSB +: 7] = barrier_number_out;
         end
         ADDR_NUMBER: rd_mux[7:0] = stored_r;
         default: rd_mux = '0;
      endcase
   end

   // One wait state: the answer is registered in the first access cycle.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else begin
         pready_r <= access;
         if (access) begin
            pslverr_r <= ~mapped;
            prdata_r <= rd_mux;
         end
      end
   end
   assign pready_out = pready_r;
   assign pslverr_out = pslverr_r;
   assign prdata_out = prdata_r;

   // A write to the transmit register while a character is going out is dropped.
   assign tx_start = wr_done && (paddr_in == ADDR_TXDATA) && !uart_busy;

   txh_uart #(
      .CLKS_PER_BIT(CLKS_PER_BIT)
   ) u_uart (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .tx_start_in(tx_start),
      .tx_data_in(pwdata_in[7:0]),
      .tx_busy_out(uart_busy),
      .line_tx_out(rs485_tx_out),
      .line_de_out(rs485_de_out),
      .line_rx_in(rs485_rx_in),
      .rx_valid_out(uart_rx_valid),
      .rx_data_out(uart_rx_data),
      .rx_ferr_out(uart_rx_ferr)
   );

   // A new character wins over the read that would clear the flag.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rx_valid_r <= 1'b0;
         rx_ferr_r <= 1'b0;
         rx_data_r <= '0;
      end else if (uart_rx_valid) begin
         rx_valid_r <= 1'b1;
         rx_ferr_r <= uart_rx_ferr;
         rx_data_r <= uart_rx_data;
      end else if (rd_done && paddr_in == ADDR_RXDATA) begin
         rx_valid_r <= 1'b0;
      end
   end

   assign sw.tens = tens_digit_switch_in;
   assign sw.units = units_digit_switch_in;
   assign sw_zero = (sw == '0);
   assign sw_valid = (sw.tens <= DIGIT_MAX) && (sw.units <= DIGIT_MAX);
   assign btn_rel = btn_q_r & ~lock_pushbutton_in;
   assign tmp_close = ~tmp_q_r & tamper_switch_in;
   assign wr_digits = pwdata_in[7:0];
   // Bus renumbering only in remote mode
   assign num_wr_ok = wr_done && (paddr_in == ADDR_NUMBER) && (num_st_r == ST_REMOTE) && !locked_r &&
                      (wr_digits != '0) && (wr_digits.tens <= DIGIT_MAX) && (wr_digits.units <= DIGIT_MAX);

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         btn_q_r <= 1'b0;
         tmp_q_r <= 1'b0;
      end else begin
         btn_q_r <= lock_pushbutton_in;
         tmp_q_r <= tamper_switch_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         num_st_r <= ST_LOCAL;
         stored_r <= '0;
         have_r <= 1'b0;
         locked_r <= 1'b0;
         show_cnt_r <= '0;
      end else begin
         unique case (num_st_r)
            ST_LOCAL: begin
               if (btn_rel && sw_zero) begin
                  num_st_r <= ST_ARMED;
               end
            end
            ST_REMOTE: begin
               if (btn_rel) begin
                  if (sw_zero) begin
                     num_st_r <= ST_ARMED;
                  end else begin
                     locked_r <= 1'b1;
                  end
               end else if (num_wr_ok) begin
                  stored_r <= wr_digits;
               end
            end
            ST_ARMED: begin
               if (btn_rel && !sw_zero) begin
                  num_st_r <= ST_LOCAL;
               end else if (tmp_close && !sw_zero && sw_valid) begin
                  if (have_r && sw == stored_r) begin
                     num_st_r <= ST_REMOTE;
                  end else begin
                     stored_r <= sw;
                     have_r <= 1'b1;
                     locked_r <= 1'b0;
                     show_cnt_r <= '0;
                     num_st_r <= ST_SHOW_ON;
                  end
               end
            end
            ST_SHOW_ON, ST_SHOW_OFF: begin
               if (show_cnt_r == SHOW_LAST) begin
                  show_cnt_r <= '0;
                  num_st_r <= (num_st_r == ST_SHOW_ON) ? ST_SHOW_OFF : ST_REMOTE;
               end else begin
                  show_cnt_r <= show_cnt_r + 1'b1;
               end
            end
            default: num_st_r <= ST_LOCAL;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         barrier_number_out <= NUMBER_OF_ZERO;
      end else if (num_st_r == ST_LOCAL || !have_r) begin
         barrier_number_out <= sw_zero ? NUMBER_OF_ZERO : digits_to_bin(sw);
      end else begin
         barrier_number_out <= digits_to_bin(stored_r);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         fault_tens_indicator_out <= 1'b0;
         tamper_units_indicator_out <= 1'b0;
      end else begin
         unique case (num_st_r)
            ST_SHOW_ON: begin
               fault_tens_indicator_out <= 1'b1;
               tamper_units_indicator_out <= 1'b1;
            end
            ST_SHOW_OFF: begin
               fault_tens_indicator_out <= 1'b0;
               tamper_units_indicator_out <= 1'b0;
            end
            ST_ARMED: begin
               fault_tens_indicator_out <= have_r && (sw.tens == stored_r.tens);
               tamper_units_indicator_out <= have_r && (sw.units == stored_r.units);
            end
            default: begin
               fault_tens_indicator_out <= fault_cond_in;
               tamper_units_indicator_out <= tamper_cond_in;
            end
         endcase
      end
   end

   assign slave = sync_role_jumper_in;
   assign active_ch = slave ? slave_ch_r : channel_selector_in;
   assign sync_half = SYNC_CNT_W'(SYNC_UNIT) * SYNC_CNT_W'({1'b0, channel_selector_in} + 5'h01);

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sync_cnt_r <= '0;
         sync_out <= 1'b0;
         sync_oe_out <= 1'b0;
      end else begin
         sync_oe_out <= ~slave;
         if (sync_cnt_r >= sync_half - 1'b1) begin
            sync_cnt_r <= '0;
            sync_out <= ~sync_out;
         end else begin
            sync_cnt_r <= sync_cnt_r + 1'b1;
         end
      end
   end

   // The high time of the sync wave, in units, is the master's channel number plus one.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sync_q_r <= 1'b0;
         sync_pre_r <= '0;
         sync_units_r <= '0;
         slave_ch_r <= '0;
      end else begin
         sync_q_r <= sync_in;
         if (sync_in && !sync_q_r) begin
            sync_pre_r <= '0;
            sync_units_r <= '0;
         end else if (sync_in) begin
            if (sync_pre_r == SYNC_UNIT_LAST) begin
               sync_pre_r <= '0;
               if (sync_units_r != CHAN_NO_ALARM) begin
                  sync_units_r <= sync_units_r + 1'b1;
               end
            end else begin
               sync_pre_r <= sync_pre_r + 1'b1;
            end
         end else if (sync_q_r) begin
            slave_ch_r <= sync_units_r;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         modulation_channel_out <= '0;
         alarm_event_out <= 1'b0;
         tamper_event_out <= 1'b0;
         fault_event_out <= 1'b0;
      end else begin
         modulation_channel_out <= active_ch;
         alarm_event_out <= intrusion_in | (channel_alarm_in & (active_ch != CHAN_NO_ALARM));
         tamper_event_out <= tamper_cond_in;
         fault_event_out <= fault_cond_in;
      end
   end
endmodule : txh_top

// >>> rtl/txh_pkg.sv
// Shared constants, register map and types of the transmitter head configuration block.
package txh_pkg;
   // Core clock and serial framing.
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned BIT_RATE = 9600;
   localparam int unsigned CLKS_PER_BIT_DFLT = CLK_HZ / BIT_RATE;
   localparam int unsigned DATA_BITS = 8;
   localparam int unsigned STOP_BITS = 1;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic LINE_START = 1'b0;
   localparam logic [2:0] LAST_BIT_IDX = 3'h7;

   // Confirmation flash of the indicators, in milliseconds.
   localparam int unsigned SHOW_TIME_MS = 3000;
   localparam int unsigned SHOW_CYCLES_DFLT = (CLK_HZ / 1000) * SHOW_TIME_MS;

   // Sync line: each half period lasts (channel + 1) units.
   localparam int unsigned SYNC_UNIT_DFLT = 64;
   localparam int unsigned SYNC_CNT_W = 16;

   // Channel and barrier number coding.
   localparam logic [3:0] CHAN_NO_ALARM = 4'hf;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [6:0] DIGIT_WEIGHT_TENS = 7'h0a;
   localparam logic [6:0] NUMBER_OF_ZERO = 7'h64;

   // Register byte offsets.
   localparam logic [7:0] ADDR_TXDATA = 8'h00;
   localparam logic [7:0] ADDR_RXDATA = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_NUMBER = 8'h0c;

   // Field positions.
   localparam int unsigned RX_VALID_BIT = 8;
   localparam int unsigned RX_FERR_BIT = 9;
   localparam int unsigned ST_CHAN_LSB = 0;
   localparam int unsigned ST_SLAVE_BIT = 4;
   localparam int unsigned ST_STATE_LSB = 5;
   localparam int unsigned ST_LOCKED_BIT = 8;
   localparam int unsigned ST_REMOTE_BIT = 9;
   localparam int unsigned ST_TXBUSY_BIT = 10;
   localparam int unsigned ST_NUMBER_LSB = 12;

   typedef struct packed {
      logic [3:0] tens;
      logic [3:0] units;
   } txh_digits_t;

   typedef enum logic [2:0] {
      ST_LOCAL = 3'b000,
      ST_ARMED = 3'b001,
      ST_SHOW_ON = 3'b010,
      ST_SHOW_OFF = 3'b011,
      ST_REMOTE = 3'b100
   } txh_num_state_t;

   typedef enum logic [1:0] {
      U_IDLE = 2'b00,
      U_START = 2'b01,
      U_DATA = 2'b10,
      U_STOP = 2'b11
   } txh_uart_state_t;
endpackage : txh_pkg

// >>> rtl/txh_uart.sv
// Half-duplex asynchronous character engine for the RS-485 line.
`timescale 1ns/100ps
module txh_uart
   import txh_pkg::*;
#(
   parameter int unsigned CLKS_PER_BIT = CLKS_PER_BIT_DFLT
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic tx_start_in,
   input wire logic [7:0] tx_data_in,
   output logic tx_busy_out,
   output logic line_tx_out,
   output logic line_de_out,
   input wire logic line_rx_in,
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   output logic rx_ferr_out
);
   localparam int unsigned CW = $clog2(CLKS_PER_BIT + 1);
   localparam logic [CW-1:0] LAST = CW'(CLKS_PER_BIT - 1);
   localparam logic [CW-1:0] HALF = CW'(CLKS_PER_BIT / 2);

   txh_uart_state_t tx_st_r;
   txh_uart_state_t rx_st_r;
   logic [CW-1:0] tx_cnt_r;
   logic [CW-1:0] rx_cnt_r;
   logic [2:0] tx_idx_r;
   logic [2:0] rx_idx_r;
   logic [7:0] tx_sh_r;
   logic [7:0] rx_sh_r;

   assign tx_busy_out = (tx_st_r != U_IDLE);

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         tx_st_r <= U_IDLE;
         tx_cnt_r <= '0;
         tx_idx_r <= '0;
         tx_sh_r <= '0;
         line_tx_out <= LINE_IDLE;
         line_de_out <= 1'b0;
      end else begin
         unique case (tx_st_r)
            U_IDLE: begin
               if (tx_start_in) begin
                  tx_sh_r <= tx_data_in;
                  tx_cnt_r <= '0;
                  line_tx_out <= LINE_START;
                  line_de_out <= 1'b1;
                  tx_st_r <= U_START;
               end
            end
            U_START: begin
               if (tx_cnt_r == LAST) begin
                  tx_cnt_r <= '0;
                  tx_idx_r <= '0;
                  line_tx_out <= tx_sh_r[0];
                  tx_st_r <= U_DATA;
               end else begin
                  tx_cnt_r <= tx_cnt_r + 1'b1;
               end
            end
            U_DATA: begin
               if (tx_cnt_r == LAST) begin
                  tx_cnt_r <= '0;
                  if (tx_idx_r == LAST_BIT_IDX) begin
                     line_tx_out <= LINE_IDLE;
                     tx_st_r <= U_STOP;
                  end else begin
                     tx_idx_r <= tx_idx_r + 1'b1;
                     tx_sh_r <= tx_sh_r >> 1;
                     line_tx_out <= tx_sh_r[1];
                  end
               end else begin
                  tx_cnt_r <= tx_cnt_r + 1'b1;
               end
            end
            U_STOP: begin
               if (tx_cnt_r == LAST) begin
                  tx_cnt_r <= '0;
                  line_de_out <= 1'b0;
                  tx_st_r <= U_IDLE;
               end else begin
                  tx_cnt_r <= tx_cnt_r + 1'b1;
               end
            end
         endcase
      end
   end

   // The receiver only looks for a start bit while our own driver is off, so it never starts decoding its own echo.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rx_st_r <= U_IDLE;
         rx_cnt_r <= '0;
         rx_idx_r <= '0;
         rx_sh_r <= '0;
         rx_valid_out <= 1'b0;
         rx_data_out <= '0;
         rx_ferr_out <= 1'b0;
      end else begin
         rx_valid_out <= 1'b0;
         unique case (rx_st_r)
            U_IDLE: begin
               if (tx_st_r == U_IDLE && line_rx_in == LINE_START) begin
                  rx_cnt_r <= '0;
                  rx_st_r <= U_START;
               end
            end
            U_START: begin
               if (rx_cnt_r == HALF) begin
                  rx_cnt_r <= '0;
                  rx_idx_r <= '0;
                  rx_st_r <= (line_rx_in == LINE_START) ? U_DATA : U_IDLE;
               end else begin
                  rx_cnt_r <= rx_cnt_r + 1'b1;
               end
            end
            U_DATA: begin
               if (rx_cnt_r == LAST) begin
                  rx_cnt_r <= '0;
                  rx_sh_r <= {line_rx_in, rx_sh_r[7:1]};
                  if (rx_idx_r == LAST_BIT_IDX) begin
                     rx_st_r <= U_STOP;
                  end else begin
                     rx_idx_r <= rx_idx_r + 1'b1;
                  end
               end else begin
                  rx_cnt_r <= rx_cnt_r + 1'b1;
               end
            end
            U_STOP: begin
               if (rx_cnt_r == LAST) begin
                  rx_cnt_r <= '0;
                  rx_data_out <= rx_sh_r;
                  rx_ferr_out <= (line_rx_in != LINE_IDLE);
                  rx_valid_out <= 1'b1;
                  rx_st_r <= U_IDLE;
               end else begin
                  rx_cnt_r <= rx_cnt_r + 1'b1;
               end
            end
         endcase
      end
   end
endmodule : txh_uart

// >>> tb/txh_top_assertions.sv
// Port-level checks of the transmitter head configuration block.
`timescale 1ns/100ps
module txh_top_chk
   import txh_pkg::*;
#(
   parameter int unsigned CLKS_PER_BIT = CLKS_PER_BIT_DFLT
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic rs485_tx_out,
   input wire logic rs485_de_out,
   input wire logic [3:0] channel_selector_in,
   input wire logic sync_role_jumper_in,
   input wire logic sync_oe_out,
   input wire logic channel_alarm_in,
   input wire logic intrusion_in,
   input wire logic [3:0] modulation_channel_out,
   input wire logic alarm_event_out
);
   localparam int STOP_AT = 9 * CLKS_PER_BIT;
   localparam int LAST_AT = 10 * CLKS_PER_BIT - 1;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   sequence char_go;
      $rose(rs485_de_out);
   endsequence
   sequence char_end;
      ##LAST_AT rs485_de_out ##1 !rs485_de_out;
   endsequence
   idle_high_a: assert property (!rs485_de_out |-> rs485_tx_out)
      else $error("released line not high");
   start_low_a: assert property (char_go |-> !rs485_tx_out)
      else $error("start bit not low");
   stop_high_a: assert property (char_go |-> ##STOP_AT rs485_tx_out)
      else $error("stop bit not high");
   frame_len_a: assert property (char_go |-> char_end)
      else $error("driver enable length wrong");
   chan_f_mask_a: assert property ((channel_alarm_in && !intrusion_in)
      |=> (modulation_channel_out == CHAN_NO_ALARM) != alarm_event_out)
      else $error("alarm on channel f");
   chan_alarm_a: assert property ((!channel_alarm_in && !intrusion_in) |=> !alarm_event_out)
      else $error("stray alarm");
   intrusion_a: assert property (intrusion_in |=> alarm_event_out)
      else $error("intrusion masked");
   chan_follow_a: assert property ((!sync_role_jumper_in && !$past(sync_role_jumper_in) && !$past(rst_in))
      |-> modulation_channel_out == $past(channel_selector_in))
      else $error("master channel not selector");
   sync_dir_a: assert property (!$past(rst_in) |-> sync_oe_out == !$past(sync_role_jumper_in))
      else $error("sync direction wrong");
endmodule : txh_top_chk
bind txh_top txh_top_chk #(.CLKS_PER_BIT(CLKS_PER_BIT)) i_txh_top_chk (.core_clk_in, .rst_in, .rs485_tx_out,
   .rs485_de_out, .channel_selector_in, .sync_role_jumper_in, .sync_oe_out, .channel_alarm_in, .intrusion_in,
   .modulation_channel_out, .alarm_event_out);

// >>> tb/txh_pc_model.sv
// Maintenance PC on the RS-485 bus: sends characters and captures what it hears.
`timescale 1ns/100ps
module txh_pc_model
   import txh_pkg::*;
#(
   parameter int unsigned CLKS_PER_BIT = 8
) (
   input wire logic core_clk_in,
   input wire logic line_in,
   output logic pc_tx_out,
   output logic [7:0] rx_byte_out
);
   initial pc_tx_out = LINE_IDLE;
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {LINE_IDLE, b, LINE_START};
      for (int i = 0; i < 10; i++) begin
         pc_tx_out <= f[i];
         repeat (CLKS_PER_BIT) @(posedge core_clk_in);
      end
   endtask : send
   // one listener among the nodes; samples mid-bit
   always begin
      @(negedge line_in);
      repeat (CLKS_PER_BIT / 2) @(posedge core_clk_in);
      for (int k = 0; k < 8; k++) begin
         repeat (CLKS_PER_BIT) @(posedge core_clk_in);
         rx_byte_out[k] = line_in;
      end
      repeat (CLKS_PER_BIT) @(posedge core_clk_in);
   end
endmodule : txh_pc_model

// >>> tb/tb_top.sv
// Self-checking bench for the transmitter head configuration block.
`timescale 1ns/100ps
module tb_top;
   import txh_pkg::*;
   localparam int unsigned NB = 8;
   localparam int unsigned SHOW = 20;
   logic core_clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out, rs485_tx_out, rs485_de_out, pc_tx, sync_oe_out, alarm_event_out, err;
   logic [3:0] channel_selector_in = 4'h0, units_digit_switch_in = 4'h0, tens_digit_switch_in = 4'h0;
   logic lock_pushbutton_in = 1'b0, tamper_switch_in = 1'b0, sync_role_jumper_in = 1'b0, sync_in = 1'b0;
   logic channel_alarm_in = 1'b0, intrusion_in = 1'b0, tamper_cond_in = 1'b0, fault_cond_in = 1'b0;
   logic [3:0] modulation_channel_out;
   logic [6:0] barrier_number_out;
   logic fault_tens_indicator_out, tamper_units_indicator_out, sync_out, tamper_event_out, fault_event_out;
   logic [7:0] rxb;
   logic [31:0] r;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   wire logic [1:0] leds = {fault_tens_indicator_out, tamper_units_indicator_out};
   // released bus follows the PC transmitter, which idles high
   wire logic rs485_rx_in = rs485_de_out ? rs485_tx_out : pc_tx;
   txh_top #(.CLKS_PER_BIT(NB), .SHOW_CYCLES(SHOW), .SYNC_UNIT(4)) i_txh_top (.core_clk_in, .rst_in, .psel_in,
      .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .rs485_rx_in,
      .rs485_tx_out, .rs485_de_out, .channel_selector_in, .units_digit_switch_in, .tens_digit_switch_in,
      .lock_pushbutton_in, .tamper_switch_in, .sync_role_jumper_in, .sync_in, .sync_out, .sync_oe_out,
      .channel_alarm_in, .intrusion_in, .tamper_cond_in, .fault_cond_in, .modulation_channel_out,
      .barrier_number_out, .alarm_event_out, .tamper_event_out, .fault_event_out, .fault_tens_indicator_out,
      .tamper_units_indicator_out);
   txh_pc_model #(.CLKS_PER_BIT(NB)) i_txh_pc_model (.core_clk_in, .line_in(rs485_rx_in), .pc_tx_out(pc_tx),
      .rx_byte_out(rxb));
   always #2.5 core_clk_in = ~core_clk_in;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask : tick
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      do @(posedge core_clk_in); while (pready_out !== 1'b1);
      r = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb
   task automatic dial(input logic [3:0] t, input logic [3:0] u);
      tens_digit_switch_in <= t;
      units_digit_switch_in <= u;
      tick(3);
   endtask : dial
   task automatic press();
      lock_pushbutton_in <= 1'b1;
      tick(3);
      lock_pushbutton_in <= 1'b0;
      tick(3);
   endtask : press
   task automatic t_local();
      dial(4'h4, 4'h2);
      check(barrier_number_out, 7'h2a);
      dial(4'h0, 4'h0);
      check(barrier_number_out, 7'h64);
      dial(4'h4, 4'h2);
      apb(1'b1, ADDR_NUMBER, 32'h13);
      apb(1'b1, 8'h10, 32'h1);
      check(err, 1'b1);
      check(barrier_number_out, 7'h2a);
      dial(4'h0, 4'h0);
      press();
      dial(4'h1, 4'h2);
      press();
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(r[ST_STATE_LSB +: 3], ST_LOCAL);
      $display("t_local done");
   endtask : t_local
   task automatic t_serial();
      apb(1'b1, ADDR_TXDATA, 32'ha5);
      tick(10 * NB + 4);
      check(rxb, 8'ha5);
      i_txh_pc_model.send(8'h3c);
      tick(NB);
      apb(1'b0, ADDR_RXDATA, 32'h0);
      check(r, 32'h13c);
      $display("t_serial done");
   endtask : t_serial
   task automatic t_chan();
      for (int c = 0; c < 16; c++) begin
         channel_selector_in <= c[3:0];
         tick(2);
         check(modulation_channel_out, c[3:0]);
      end
      channel_alarm_in <= 1'b1;
      tick(3);
      check(alarm_event_out, 1'b0);
      intrusion_in <= 1'b1;
      tamper_cond_in <= 1'b1;
      tick(2);
      check(alarm_event_out, 1'b1);
      check(tamper_event_out, 1'b1);
      intrusion_in <= 1'b0;
      tamper_cond_in <= 1'b0;
      channel_selector_in <= 4'h3;
      tick(3);
      check(alarm_event_out, 1'b1);
      channel_alarm_in <= 1'b0;
      sync_role_jumper_in <= 1'b1;
      tick(2);
      check(sync_oe_out, 1'b0);
      sync_in <= 1'b1;
      tick(24);
      sync_in <= 1'b0;
      tick(3);
      check(modulation_channel_out, 4'h5);
      channel_selector_in <= 4'h2;
      repeat (64) begin
         tick(1);
         sync_in <= sync_out;
      end
      check(modulation_channel_out, 4'h2);
      sync_role_jumper_in <= 1'b0;
      $display("t_chan done");
   endtask : t_chan
   task automatic t_remote();
      dial(4'h0, 4'h0);
      press();
      dial(4'h5, 4'h7);
      tamper_switch_in <= 1'b1;
      tick(6);
      check(leds, 2'b11);
      tick(SHOW);
      check(leds, 2'b00);
      tick(SHOW);
      fault_cond_in <= 1'b1;
      tick(3);
      check(leds, 2'b10);
      check(fault_event_out, 1'b1);
      check(barrier_number_out, 7'h39);
      fault_cond_in <= 1'b0;
      tamper_switch_in <= 1'b0;
      apb(1'b1, ADDR_NUMBER, 32'h23);
      tick(2);
      check(barrier_number_out, 7'h17);
      press();
      apb(1'b1, ADDR_NUMBER, 32'h31);
      tick(2);
      check(barrier_number_out, 7'h17);
      $display("t_remote done");
   endtask : t_remote
   task automatic t_readback();
      dial(4'h0, 4'h0);
      press();
      dial(4'h2, 4'h3);
      check(leds, 2'b11);
      dial(4'h2, 4'h4);
      check(leds, 2'b10);
      dial(4'h2, 4'h3);
      tamper_switch_in <= 1'b1;
      tick(4);
      check(barrier_number_out, 7'h17);
      tamper_switch_in <= 1'b0;
      $display("t_readback done");
   endtask : t_readback
   task automatic stop_test();
      $display("checks %0d bad %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   // A hung handshake ends the run here.
   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      tick(2);
      rst_in <= 1'b0;
      t_local();
      t_serial();
      t_chan();
      t_remote();
      t_readback();
      stop_test();
   end
endmodule : tb_top
